// ### src/call_line_defs.svh
// Timing constants for the call line control latches
`ifndef CALL_LINE_DEFS_SVH
`define CALL_LINE_DEFS_SVH

`define CLK_PERIOD_NS 10
`define TIMER_INTERVAL_MS 2300
// Widened to 64 bits: the product overflows a plain 32-bit integer
`define TIMER_CYCLES ((64'(`TIMER_INTERVAL_MS) * 64'h00000000000F4240) / 64'(`CLK_PERIOD_NS))
`define CONN_FILTER_US 20000
`define CONN_FILTER_CYCLES ((`CONN_FILTER_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DIAL_FILTER_US 1000
`define DIAL_FILTER_CYCLES ((`DIAL_FILTER_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_WIDTH 28

`endif

// ### src/call_line_pkg.sv
// Types for the call line control latches
package call_line_pkg;
	typedef enum logic [2:0] {
		POL_NEUTRAL = 3'h1,
		POL_POS = 3'h2,
		POL_NEG = 3'h4
	} polarity_t;
endpackage : call_line_pkg

// ### src/line_filter.sv
// Persistence filter: output follows input only after it holds for a set time
`timescale 1ns/1ps
`include "call_line_defs.svh"

module line_filter #(
	parameter logic [`CNT_WIDTH-1:0] HOLD_CYCLES = 28'h0000001
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic raw_in,
	input wire logic reset_value,
	output logic filt_out
);
	logic [`CNT_WIDTH-1:0] count_reg;
	logic filt_reg;
	wire logic differs = raw_in != filt_reg;
	wire logic expired = count_reg >= HOLD_CYCLES - 28'h0000001;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			count_reg <= 28'h0000000;
			filt_reg <= 1'b0;
		end else if (!differs) begin
			count_reg <= 28'h0000000;
		end else if (expired) begin
			count_reg <= 28'h0000000;
			filt_reg <= raw_in;
		end else begin
			count_reg <= count_reg + 28'h0000001;
		end
	end

	// Reset value applied combinationally only while in reset
	assign filt_out = sys_rst ? reset_value : filt_reg;
endmodule : line_filter

// ### src/call_line_control_latches.sv
// Proceed-to-dial, connect and local latches with local auto-off timer
`timescale 1ns/1ps
`include "call_line_defs.svh"

module call_line_control_latches (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic line_pos,
	input wire logic line_neg,
	input wire logic loop_low,
	input wire logic start_btn,
	input wire logic stop_btn,
	input wire logic local_btn,
	output logic dial_relay,
	output logic connect_relay,
	output logic local_relay,
	output logic motor_relay,
	output logic timer_pulse
);
	////////////////////////////////////////////////////////////////
	// Input filtering
	logic pos_filt;
	logic neg_filt;
	logic low_filt;

	line_filter #(.HOLD_CYCLES(28'(`CONN_FILTER_CYCLES))) u_pos_filter (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.raw_in(line_pos),
		.reset_value(1'b0),
		.filt_out(pos_filt)
	);

	line_filter #(.HOLD_CYCLES(28'(`CONN_FILTER_CYCLES))) u_neg_filter (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.raw_in(line_neg),
		.reset_value(1'b0),
		.filt_out(neg_filt)
	);

	line_filter #(.HOLD_CYCLES(28'(`DIAL_FILTER_CYCLES))) u_low_filter (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.raw_in(loop_low),
		.reset_value(1'b0),
		.filt_out(low_filt)
	);

	////////////////////////////////////////////////////////////////
	// Polarity decode
	call_line_pkg::polarity_t pol;
	// Both asserted is contradictory; treated as neutral to avoid toggling
	assign pol = (pos_filt && !neg_filt) ? call_line_pkg::POL_POS :
		(neg_filt && !pos_filt) ? call_line_pkg::POL_NEG : call_line_pkg::POL_NEUTRAL;

	////////////////////////////////////////////////////////////////
	// Latch state
	logic dial_reg;
	logic conn_reg;
	logic local_reg;
	logic motor_reg;
	logic pulse_reg;
	logic first_done_reg;
	logic [`CNT_WIDTH-1:0] timer_reg;

	logic conn_next;
	always_comb begin
		conn_next = conn_reg;
		unique case (pol)
			call_line_pkg::POL_POS: conn_next = 1'b1;
			call_line_pkg::POL_NEG: conn_next = 1'b0;
			call_line_pkg::POL_NEUTRAL: conn_next = conn_reg;
		endcase
	end

	// Start button gates the line signal, so breaks alone cannot dial
	wire logic dial_set = start_btn && low_filt;
	wire logic dial_clr = stop_btn || conn_reg;
	wire logic dial_next = dial_clr ? 1'b0 : (dial_set ? 1'b1 : dial_reg);

	wire logic timer_done = timer_reg >= 28'(`TIMER_CYCLES) - 28'h0000001;
	wire logic timer_fire = conn_reg && timer_done;
	wire logic local_kill = timer_fire && !first_done_reg;
	wire logic local_set = local_btn && !dial_reg && !conn_reg;
	wire logic local_clr = start_btn || stop_btn || local_kill;
	wire logic local_next = local_clr ? 1'b0 : (local_set ? 1'b1 : local_reg);

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			dial_reg <= 1'b0;
			conn_reg <= 1'b0;
			local_reg <= 1'b0;
			motor_reg <= 1'b0;
			pulse_reg <= 1'b0;
			first_done_reg <= 1'b0;
			timer_reg <= 28'h0000000;
		end else begin
			dial_reg <= dial_next;
			conn_reg <= conn_next;
			local_reg <= local_next;
			motor_reg <= conn_next || local_next;
			pulse_reg <= timer_fire;
			if (!conn_reg) begin
				timer_reg <= 28'h0000000;
				first_done_reg <= 1'b0;
			end else if (timer_done) begin
				timer_reg <= 28'h0000000;
				first_done_reg <= 1'b1;
			end else begin
				timer_reg <= timer_reg + 28'h0000001;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Relay drives
	assign dial_relay = dial_reg;
	assign connect_relay = conn_reg;
	assign local_relay = local_reg;
	assign motor_relay = motor_reg;
	assign timer_pulse = pulse_reg;
endmodule : call_line_control_latches

// ### testbench/line_exchange.sv
// Exchange side of the loop: polarity and loop current
`timescale 1ns/1ps
module line_exchange (
	input wire logic give_dial,
	input wire logic reverse,
	output logic line_pos,
	output logic line_neg,
	output logic loop_low
);
	// Idle loop rests at negative polarity
	assign line_pos = reverse;
	assign line_neg = ~reverse;
	assign loop_low = give_dial;
endmodule : line_exchange

// ### testbench/call_line_asserts.sv
// Port checks for the call line control latches
`timescale 1ns/1ps
module call_line_asserts (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic line_pos,
	input wire logic line_neg,
	input wire logic start_btn,
	input wire logic stop_btn,
	input wire logic local_btn,
	input wire logic dial_relay,
	input wire logic connect_relay,
	input wire logic local_relay,
	input wire logic motor_relay,
	input wire logic timer_pulse
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	sequence s_quiet;
		!connect_relay ##1 !connect_relay;
	endsequence
	a_motor_or: assert property (motor_relay == (connect_relay | local_relay))
		else $error("motor relay wrong");
	a_local_set: assert property (local_btn && !start_btn && !stop_btn && !dial_relay
		&& !connect_relay |=> local_relay) else $error("local not set");
	a_local_block: assert property (!local_relay && (dial_relay || connect_relay)
		|=> !local_relay) else $error("local set while blocked");
	a_local_clear: assert property (start_btn || stop_btn |=> !local_relay)
		else $error("local not cleared");
	a_dial_clear: assert property (stop_btn || connect_relay |=> !dial_relay)
		else $error("dial not cleared");
	a_dial_gate: assert property (!dial_relay && !start_btn |=> !dial_relay)
		else $error("dial set without start");
	a_conn_rise: assert property ($rose(connect_relay) |-> $past(line_pos && !line_neg, 2))
		else $error("connect set without polarity");
	a_conn_fall: assert property ($fell(connect_relay) |-> $past(line_neg && !line_pos, 2))
		else $error("connect cleared without polarity");
	a_timer_idle: assert property (s_quiet |-> !timer_pulse)
		else $error("timer pulse while idle");
	a_pulse_one: assert property (timer_pulse |=> !timer_pulse)
		else $error("timer pulse too long");
endmodule : call_line_asserts
//////////////////////////////////////////////////
bind call_line_control_latches call_line_asserts chk (.core_clk(core_clk), .sys_rst(sys_rst),
	.line_pos(line_pos), .line_neg(line_neg), .start_btn(start_btn), .stop_btn(stop_btn),
	.local_btn(local_btn), .dial_relay(dial_relay), .connect_relay(connect_relay),
	.local_relay(local_relay), .motor_relay(motor_relay), .timer_pulse(timer_pulse));

// ### testbench/tb_call_line_control_latches.sv
// Testbench for the call line control latches
`timescale 1ns/1ps
module tb_call_line_control_latches;
	logic core_clk, sys_rst, start_btn, stop_btn, local_btn, give_dial;
	wire logic line_pos, line_neg, loop_low, dial_relay, connect_relay, local_relay, motor_relay;
	wire logic timer_pulse;
	int fail_count, checked;
	line_exchange ex (.give_dial(give_dial), .reverse(1'h0), .line_pos(line_pos),
		.line_neg(line_neg), .loop_low(loop_low));
	call_line_control_latches dut (.core_clk(core_clk), .sys_rst(sys_rst), .line_pos(line_pos),
		.line_neg(line_neg), .loop_low(loop_low), .start_btn(start_btn), .stop_btn(stop_btn),
		.local_btn(local_btn), .dial_relay(dial_relay), .connect_relay(connect_relay),
		.local_relay(local_relay), .motor_relay(motor_relay), .timer_pulse(timer_pulse));
	initial begin
		core_clk = 1'h0;
		forever #5 core_clk = ~core_clk;
	end
	//////////////////////////////////////////////////
	task chk(input string n, input logic e, input logic g);
		checked++;
		if (g !== e) begin
			$display("unexpected %s expected %b seen %b", n, e, g);
			fail_count++;
		end
	endtask : chk
	task btn(input logic s, input logic p, input logic l);
		{start_btn, stop_btn, local_btn} = {s, p, l};
		@(negedge core_clk);
	endtask : btn
	task stop_test;
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : stop_test
	//////////////////////////////////////////////////
	initial begin
		{sys_rst, start_btn, stop_btn, local_btn, give_dial} = 5'h10;
		fail_count = 0;
		checked = 0;
		repeat (12) @(negedge core_clk);
		sys_rst = 1'h0;
		chk("motor", 1'h0, motor_relay);
		btn(1'h0, 1'h0, 1'h1);
		chk("local", 1'h1, local_relay);
		chk("motor", 1'h1, motor_relay);
		btn(1'h1, 1'h0, 1'h1);
		chk("local", 1'h0, local_relay);
		btn(1'h0, 1'h0, 1'h1);
		btn(1'h0, 1'h1, 1'h0);
		chk("local", 1'h0, local_relay);
		$display("local test done");
		// Filter needs the full 1 ms of low current
		give_dial = 1'h1;
		btn(1'h0, 1'h0, 1'h0);
		repeat (100005) @(negedge core_clk);
		chk("dial", 1'h0, dial_relay);
		btn(1'h1, 1'h0, 1'h0);
		chk("dial", 1'h1, dial_relay);
		give_dial = 1'h0;
		btn(1'h0, 1'h0, 1'h0);
		repeat (4) @(negedge core_clk);
		chk("dial", 1'h1, dial_relay);
		btn(1'h0, 1'h0, 1'h1);
		chk("local", 1'h0, local_relay);
		btn(1'h0, 1'h1, 1'h0);
		chk("dial", 1'h0, dial_relay);
		chk("connect", 1'h0, connect_relay);
		chk("pulse", 1'h0, timer_pulse);
		$display("dial test done");
		stop_test();
	end
endmodule : tb_call_line_control_latches
